/* File: bench/ctrl_model.sv */
`default_nettype none
module ctrl_model (
   // link clock and command pins
   output logic                       ck,
   output logic                       cke,
   output logic                       cs_n,
   output logic                       ras_n,
   output logic                       cas_n,
   output logic                       we_n,
   output logic                       bank_select_lo,
   output logic                       bank_select_hi,
   output logic [dram_pkg::ROW_W-1:0] addr,
   // write data, strobe and mask
   output logic [15:0]                dq_i,
   output logic [1:0]                 dqs_i,
   output logic [1:0]                 dm_i
);
   timeunit 1ns;
   timeprecision 100ps;
   import dram_pkg::*;
   int ck_cnt = 0;

   // link clock runs free, phase unrelated to the system clock
   initial begin
      ck = 1'b0;
      #1.7;
      forever #3 ck = ~ck;
   end

   always @(posedge ck) ck_cnt <= ck_cnt + 1;

   initial begin
      cke = 1'b0;
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = CMD_NOP;
      {bank_select_hi, bank_select_lo} = 2'h0;
      addr = 13'h0;
      dq_i = 16'h0;
      dqs_i = 2'h0;
      dm_i = 2'h0;
   end

   // one command per link cycle, changed just after an edge and taken at the next
   task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [ROW_W-1:0] a,
                      input logic e = 1'b1, input logic wb = 1'b0, input logic [15:0] d = 16'h0,
                      input logic [1:0] m = 2'h0, input logic sel_n = 1'b0);
      @(posedge ck);
      #1;
      {ras_n, cas_n, we_n} = c;
      {bank_select_hi, bank_select_lo} = b;
      addr = a;
      cke = e;
      cs_n = sel_n;
      // released data lines toggle so stale data never looks valid
      dq_i = wb ? d : ~dq_i;
      dqs_i = wb ? 2'h3 : 2'h0;
      dm_i = wb ? m : ~dm_i;
   endtask

   task automatic nop();
      cmd(CMD_NOP, ~{bank_select_hi, bank_select_lo}, ~addr);
   endtask
endmodule // ctrl_model
`default_nettype wire

/* File: bench/ddr_sdram_command_core_tb.sv */
`default_nettype none
module ddr_sdram_command_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dram_pkg::*;
   typedef struct {int cyc; logic [15:0] d;} beat_t;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic ck, cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi;
   logic [ROW_W-1:0] addr;
   logic [15:0] dq_i, dq_o;
   logic [1:0] dqs_i, dqs_o, dm_i;
   logic dq_oe, dqs_oe, dll_ready, self_refresh;
   logic [3:0] bank_open;
   int n_mismatch = 0;
   int checks_done = 0;
   int seed = 32'h537c;
   beat_t exp_q[$];
   logic [7:0] mem [8];

   always #10 clk_sys = ~clk_sys;

   ctrl_model ctrl_u (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_lo, .bank_select_hi,
                      .addr, .dq_i, .dqs_i, .dm_i);
   ddr_cmd_core dut_u (.clk_sys, .rstn, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_lo,
                       .bank_select_hi, .addr, .dq_i, .dq_o, .dq_oe, .dqs_i, .dqs_o, .dqs_oe, .dm_i,
                       .bank_open, .dll_ready, .self_refresh);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic nop(input int n);
      repeat (n) ctrl_u.nop();
   endtask

   task automatic go(input logic [2:0] c, input logic [1:0] b, input logic [ROW_W-1:0] a);
      ctrl_u.cmd(c, b, a);
   endtask

   // mode set only after closing every bank
   task automatic mode(input logic [1:0] sel, input logic [ROW_W-1:0] a);
      go(CMD_PRE, 2'h0, 13'h400);
      nop(1);
      go(CMD_MRS, sel, a);
      nop(1);
   endtask

   // read beats are sampled half a link cycle after they are launched
   always @(negedge ck) begin
      beat_t e;
      if (dq_oe === 1'b1) begin
         if (exp_q.size() == 0) e = '{-1, 16'h0};
         else e = exp_q.pop_front();
         check("read cycle", ctrl_u.ck_cnt, e.cyc);
         check("read data", {16'h0, dq_o}, {16'h0, e.d});
         check("read strobe", {dqs_oe, dqs_o}, 3'h5);
      end
   end

   // stop: 0 full burst, 1 burst stop, 2 precharge during the burst
   task automatic burst(input int i, input int stop);
      logic [2:0] blc;
      logic [1:0] b, m;
      logic [15:0] d;
      logic bt, ap;
      int bl, cl, s, t, c0, c1;
      blc = 3'(i / 4 + 1);
      bl = 1 << blc;
      cl = i[0] ? 3 : 2;
      bt = i[1];
      ap = (i[0] ^ i[2] ^ i[3]) && stop == 0;
      b = 2'($random(seed));
      mode(SEL_MRS, {6'h0, 3'(cl), bt, blc});
      go(CMD_REF, 2'($random(seed)), 13'($random(seed)));
      nop(1);
      go(CMD_ACT, b, 13'($random(seed)));
      nop(1);
      for (int p = 0; p < 2; p++) begin
         go(CMD_WR, b, 13'h0);
         for (int k = 0; k < bl / 2; k++) begin
            d = 16'($random(seed));
            m = p ? 2'($random(seed)) : 2'h0;
            for (int h = 0; h < 2; h++) if (!m[h]) mem[2 * k + h] = d[8 * h +: 8];
            ctrl_u.cmd(CMD_NOP, b, 13'h0, 1'b1, 1'b1, d, m);
         end
      end
      nop(8);
      check("bank open", bank_open, 4'h1 << b);
      s = {$random(seed)} % bl;
      go(CMD_RD, b, {2'h0, ap, 10'(s)});
      t = ctrl_u.ck_cnt + 1;
      for (int k = 0; k < bl / 2; k++) begin
         c0 = bt ? s ^ (2 * k) : (s + 2 * k) % bl;
         c1 = bt ? s ^ (2 * k + 1) : (s + 2 * k + 1) % bl;
         if (stop == 0 || k < 2) exp_q.push_back('{t + cl + k, {mem[c1], mem[c0]}});
      end
      if (stop != 0) begin
         nop(2);
         go(stop == 1 ? CMD_BST : CMD_PRE, b, 13'h0);
      end
      nop(cl + bl / 2 + 2);
      if (!ap && stop != 2) go(CMD_PRE, b, 13'h0);
      nop(10);
      check("bank open", bank_open, 4'h0);
      check("beats left", exp_q.size(), 0);
      $display("test burst %0d stop %0d done", i, stop);
   endtask

   initial begin
      #400000;
      n_mismatch++;
      conclude();
   end

   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      repeat (33334) @(posedge ck);
      nop(1);
      go(CMD_PRE, 2'h0, 13'h400);
      go(CMD_MRS, SEL_EMRS, 13'h0);
      go(CMD_MRS, SEL_MRS, 13'h122);
      nop(193);
      check("dll ready", dll_ready, 1'b0);
      nop(30);
      check("dll ready", dll_ready, 1'b1);
      go(CMD_PRE, 2'h0, 13'h400);
      go(CMD_REF, 2'h0, 13'h0);
      go(CMD_REF, 2'h0, 13'h0);
      go(CMD_MRS, SEL_MRS, 13'h022);
      nop(1);
      $display("test init done");
      for (int i = 0; i < 12; i++) burst(i, 0);
      burst(8, 1);
      burst(10, 2);
      go(CMD_ACT, 2'h0, 13'h1);
      go(CMD_ACT, 2'h3, 13'h2);
      ctrl_u.cmd(CMD_ACT, 2'h1, 13'h3, 1'b1, 1'b0, 16'h0, 2'h0, 1'b1);
      nop(10);
      check("bank open", bank_open, 4'h9);
      go(CMD_PRE, 2'h3, 13'h0);
      nop(10);
      check("bank open", bank_open, 4'h1);
      go(CMD_ACT, 2'h2, 13'h4);
      go(CMD_PRE, 2'h1, 13'h400);
      nop(10);
      check("bank open", bank_open, 4'h0);
      go(CMD_ACT, 2'h2, 13'h5);
      nop(2);
      go(CMD_WR, 2'h2, 13'h400);
      for (int k = 0; k < 4; k++) ctrl_u.cmd(CMD_NOP, 2'h2, 13'h0, 1'b1, 1'b1, 16'h5a5a, 2'h0);
      nop(10);
      check("bank open", bank_open, 4'h0);
      $display("test banks done");
      ctrl_u.cmd(CMD_REF, 2'h0, 13'h0, 1'b0);
      repeat (10) ctrl_u.cmd(CMD_ACT, 2'h1, 13'h7, 1'b0);
      check("self refresh", self_refresh, 1'b1);
      check("dll ready", dll_ready, 1'b0);
      check("bank open", bank_open, 4'h0);
      nop(200);
      check("self refresh", self_refresh, 1'b0);
      go(CMD_REF, 2'h0, 13'h0);
      mode(SEL_MRS, 13'h122);
      nop(225);
      check("dll ready", dll_ready, 1'b1);
      $display("test self refresh done");
      conclude();
   end
endmodule // ddr_sdram_command_core_tb
`default_nettype wire

/* File: logic/ddr_cmd_core.sv */
`default_nettype none
module ddr_cmd_core (
   // system clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      rstn,
   // link clock and command pins
   input  wire logic                      ck,
   input  wire logic                      cke,
   input  wire logic                      cs_n,
   input  wire logic                      ras_n,
   input  wire logic                      cas_n,
   input  wire logic                      we_n,
   input  wire logic                      bank_select_lo,
   input  wire logic                      bank_select_hi,
   input  wire logic [dram_pkg::ROW_W-1:0] addr,
   // data, strobe and mask, {fall, rise} per clock
   input  wire logic [15:0]               dq_i,
   output logic      [15:0]               dq_o,
   output logic                           dq_oe,
   input  wire logic [1:0]                dqs_i,
   output logic      [1:0]                dqs_o,
   output logic                           dqs_oe,
   input  wire logic [1:0]                dm_i,
   // status in the system domain
   output logic      [3:0]                bank_open,
   output logic                           dll_ready,
   output logic                           self_refresh
);
   import dram_pkg::*;

   typedef struct packed {
      logic [2:0]                  mr_bl;
      logic                        mr_bt;
      logic [2:0]                  mr_cl;
      logic                        dll_en;
      logic                        dll_run;
      logic                        dll_lock;
      logic [7:0]                  dll_cnt;
      logic                        sref;
      logic [NBANK-1:0]            bank_act;
      logic [NBANK-1:0][ROW_W-1:0] row;
      logic [NBANK-1:0][3:0]       tras_cnt;
      logic [NBANK-1:0]            ap_pend;
      logic [NBANK-1:0][2:0]       ap_cnt;
      logic                        rd_busy;
      logic [3:0]                  rd_pos;
      logic [1:0]                  rd_bank;
      logic [MEM_COLW-1:0]         rd_col;
      logic                        wr_busy;
      logic [1:0]                  wr_beat;
      logic [1:0]                  wr_bank;
      logic [MEM_COLW-1:0]         wr_col;
      logic                        wr_ap;
      logic [15:0]                 dq_o;
      logic                        dq_oe;
      logic [1:0]                  dqs_o;
      logic                        dqs_oe;
   } link_t;

   link_t               state_r;
   link_t               state_nxt;
   logic                link_rst_n;
   logic [2:0]          cmd;
   logic [1:0]          ba;
   logic                go;
   logic [2:0]          hb;
   logic [2:0]          cl;
   logic [3:0]          rk;
   logic [MEM_AW-1:0]   ra0;
   logic [MEM_AW-1:0]   ra1;
   logic [MEM_AW-1:0]   wa0;
   logic [MEM_AW-1:0]   wa1;
   logic                we0;
   logic                we1;
   logic [7:0]          mem [0:(1<<MEM_AW)-1];

   // burst length code to link clocks per burst, two beats each
   function automatic logic [2:0] bl_half(input logic [2:0] code);
      case (code)
         BL_4:    return 3'h2;
         BL_8:    return 3'h4;
         default: return 3'h1;
      endcase
   endfunction

   function automatic logic [2:0] cl_cyc(input logic [2:0] code);
      return (code == CL_3) ? 3'h3 : 3'h2;
   endfunction

   // column of one word inside a wrapped burst
   function automatic logic [MEM_COLW-1:0] burst_col(
      input logic [MEM_COLW-1:0] st,
      input logic [2:0]          idx,
      input logic [2:0]          h,
      input logic                bt
   );
      logic [MEM_COLW-1:0] msk;
      logic [MEM_COLW-1:0] off;
      case (h)
         3'h1:    msk = 6'h01;
         3'h2:    msk = 6'h03;
         default: msk = 6'h07;
      endcase
      off = bt ? (st ^ {3'h0, idx}) : (st + {3'h0, idx});
      return (st & ~msk) | (off & msk);
   endfunction

   // reset carried into the link domain
   level_sync #(.W(1)) u_rst_sync (
      .clk   (ck),
      .rst_n (1'b1),
      .d     (rstn),
      .q     (link_rst_n)
   );

   // status levels into the system domain
   level_sync #(.W(NBANK + 2)) u_stat_sync (
      .clk   (clk_sys),
      .rst_n (rstn),
      .d     ({state_r.bank_act, state_r.dll_lock, state_r.sref}),
      .q     ({bank_open, dll_ready, self_refresh})
   );

   assign cmd = {ras_n, cas_n, we_n};
   assign ba  = {bank_select_hi, bank_select_lo};
   assign go  = cke && !cs_n && !state_r.sref;
   assign hb  = bl_half(state_r.mr_bl);
   assign cl  = cl_cyc(state_r.mr_cl);
   assign rk  = state_r.rd_pos - {1'b0, cl};

   assign ra0 = {state_r.rd_bank, state_r.row[state_r.rd_bank][1:0],
                 burst_col(state_r.rd_col, {rk[1:0], 1'b0}, hb, state_r.mr_bt)};
   assign ra1 = {state_r.rd_bank, state_r.row[state_r.rd_bank][1:0],
                 burst_col(state_r.rd_col, {rk[1:0], 1'b1}, hb, state_r.mr_bt)};
   assign wa0 = {state_r.wr_bank, state_r.row[state_r.wr_bank][1:0],
                 burst_col(state_r.wr_col, {state_r.wr_beat, 1'b0}, hb, state_r.mr_bt)};
   assign wa1 = {state_r.wr_bank, state_r.row[state_r.wr_bank][1:0],
                 burst_col(state_r.wr_col, {state_r.wr_beat, 1'b1}, hb, state_r.mr_bt)};

   // each byte is kept only when its strobe edge came and its mask is low
   assign we0 = state_r.wr_busy && dqs_i[0] && !dm_i[0];
   assign we1 = state_r.wr_busy && dqs_i[1] && !dm_i[1];

   always_ff @(posedge ck) begin
      if (we0) begin
         mem[wa0] <= dq_i[7:0];
      end
      if (we1) begin
         mem[wa1] <= dq_i[15:8];
      end
   end

   always_comb begin
      state_nxt        = state_r;
      state_nxt.dq_o   = '0;
      state_nxt.dq_oe  = 1'b0;
      state_nxt.dqs_o  = 2'h0;
      state_nxt.dqs_oe = 1'b0;

      // active time and pending automatic precharges per bank
      for (int b = 0; b < NBANK; b++) begin
         if (state_r.bank_act[b] && state_r.tras_cnt[b] < TRAS_DONE) begin
            state_nxt.tras_cnt[b] = state_r.tras_cnt[b] + 4'h1;
         end
         if (state_r.ap_pend[b]) begin
            if (state_r.ap_cnt[b] != 3'h0) begin
               state_nxt.ap_cnt[b] = state_r.ap_cnt[b] - 3'h1;
            end else if (state_r.tras_cnt[b] >= TRAS_DONE) begin
               state_nxt.bank_act[b] = 1'b0;
               state_nxt.ap_pend[b]  = 1'b0;
            end
         end
      end

      // dll lock wait after a reset
      if (state_r.dll_run) begin
         if (state_r.dll_cnt == DLL_LAST) begin
            state_nxt.dll_run  = 1'b0;
            state_nxt.dll_lock = state_r.dll_en;
         end else begin
            state_nxt.dll_cnt = state_r.dll_cnt + 8'h01;
         end
      end

      // read burst out, two words a clock
      if (state_r.rd_busy) begin
         state_nxt.rd_pos = state_r.rd_pos + 4'h1;
         if (state_r.rd_pos >= {1'b0, cl}) begin
            state_nxt.dq_o   = {mem[ra1], mem[ra0]};
            state_nxt.dq_oe  = 1'b1;
            state_nxt.dqs_o  = 2'h1;
            state_nxt.dqs_oe = 1'b1;
            if ({1'b0, rk[1:0]} == hb - 3'h1) begin
               state_nxt.rd_busy = 1'b0;
            end
         end
      end

      // write burst in, two words a clock after the command
      if (state_r.wr_busy) begin
         state_nxt.wr_beat = state_r.wr_beat + 2'h1;
         if ({1'b0, state_r.wr_beat} == hb - 3'h1) begin
            state_nxt.wr_busy = 1'b0;
            if (state_r.wr_ap) begin
               state_nxt.ap_pend[state_r.wr_bank] = 1'b1;
               state_nxt.ap_cnt[state_r.wr_bank]  = 3'h0;
            end
         end
      end

      if (state_r.sref) begin
         // only clock enable is watched here
         if (cke) begin
            state_nxt.sref   = 1'b0;
            state_nxt.dll_en = 1'b1;
         end
      end else if (!cke && !cs_n && cmd == CMD_REF) begin
         state_nxt.sref     = 1'b1;
         state_nxt.dll_en   = 1'b0;
         state_nxt.dll_lock = 1'b0;
         state_nxt.dll_run  = 1'b0;
      end else if (go) begin
         case (cmd)
            CMD_ACT: begin
               state_nxt.bank_act[ba] = 1'b1;
               state_nxt.row[ba]      = addr;
               state_nxt.tras_cnt[ba] = 4'h0;
               state_nxt.ap_pend[ba]  = 1'b0;
            end
            CMD_PRE: begin
               if (addr[AP_BIT]) begin
                  state_nxt.bank_act = '0;
                  state_nxt.ap_pend  = '0;
                  state_nxt.rd_busy  = 1'b0;
                  state_nxt.wr_busy  = 1'b0;
               end else begin
                  state_nxt.bank_act[ba] = 1'b0;
                  state_nxt.ap_pend[ba]  = 1'b0;
                  if (state_r.rd_bank == ba) begin
                     state_nxt.rd_busy = 1'b0;
                  end
                  if (state_r.wr_bank == ba) begin
                     state_nxt.wr_busy = 1'b0;
                  end
               end
            end
            CMD_WR: begin
               state_nxt.wr_busy = 1'b1;
               state_nxt.wr_beat = 2'h0;
               state_nxt.wr_bank = ba;
               state_nxt.wr_col  = addr[MEM_COLW-1:0];
               state_nxt.wr_ap   = addr[AP_BIT];
            end
            CMD_RD: begin
               state_nxt.rd_busy = 1'b1;
               state_nxt.rd_pos  = 4'h1;
               state_nxt.rd_bank = ba;
               state_nxt.rd_col  = addr[MEM_COLW-1:0];
               if (addr[AP_BIT]) begin
                  state_nxt.ap_pend[ba] = 1'b1;
                  state_nxt.ap_cnt[ba]  = hb - 3'h1;
               end
            end
            CMD_BST: begin
               state_nxt.rd_busy = 1'b0;
            end
            CMD_MRS: begin
               if (ba == SEL_MRS) begin
                  state_nxt.mr_bl = addr[BL_LSB+:3];
                  state_nxt.mr_bt = addr[BT_BIT];
                  state_nxt.mr_cl = addr[CL_LSB+:3];
                  if (addr[DLL_RST_BIT]) begin
                     state_nxt.dll_run  = 1'b1;
                     state_nxt.dll_cnt  = 8'h00;
                     state_nxt.dll_lock = 1'b0;
                  end
               end else if (ba == SEL_EMRS) begin
                  state_nxt.dll_en = !addr[DLL_DIS_BIT];
                  if (addr[DLL_DIS_BIT]) begin
                     state_nxt.dll_lock = 1'b0;
                  end
               end
            end
            // refresh rows come from inside; address and bank are ignored
            CMD_REF: ;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ck) begin
      if (!link_rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign dq_o   = state_r.dq_o;
   assign dq_oe  = state_r.dq_oe;
   assign dqs_o  = state_r.dqs_o;
   assign dqs_oe = state_r.dqs_oe;

   // checks, all in the link domain
   localparam int AGE_LOCK = DLL_LOCK_CYC;
   logic       dll_rst_cmd;
   logic [8:0] dll_age;

   assign dll_rst_cmd = go && cmd == CMD_MRS && ba == SEL_MRS && addr[DLL_RST_BIT];

   always_ff @(posedge ck) begin
      if (!link_rst_n || dll_rst_cmd) begin
         dll_age <= 9'h000;
      end else if (dll_age != 9'h1ff) begin
         dll_age <= dll_age + 9'h001;
      end
   end

   default clocking cb @(posedge ck);
   endclocking
   default disable iff (!link_rst_n);

   sequence rd_cl2_s;
      go && cmd == CMD_RD && !state_r.rd_busy && state_r.mr_cl == CL_2;
   endsequence
   sequence rd_cl3_s;
      go && cmd == CMD_RD && !state_r.rd_busy && state_r.mr_cl == CL_3;
   endsequence
   sequence quiet_s;
      !(go && (cmd == CMD_BST || cmd == CMD_PRE || cmd == CMD_RD));
   endsequence

   act_opens_a: assert property (go && cmd == CMD_ACT |=> state_r.bank_act[$past(ba)])
      else $error("activate did not open the bank");
   pre_all_a: assert property (go && cmd == CMD_PRE && addr[AP_BIT] |=> state_r.bank_act == '0)
      else $error("precharge all left a bank open");
   read_cl2_a: assert property (rd_cl2_s ##1 quiet_s |-> !state_r.dq_oe [*2] ##1 state_r.dq_oe)
      else $error("read data not at latency two");
   read_cl3_a: assert property (rd_cl3_s ##1 quiet_s [*2] |-> !state_r.dq_oe [*2] ##1 state_r.dq_oe)
      else $error("read data not at latency three");
   burst_stop_a: assert property (go && cmd == CMD_BST |=> !state_r.rd_busy ##1 !state_r.dq_oe)
      else $error("burst stop did not end the read");
   dll_wait_a: assert property ($rose(state_r.dll_lock) |-> dll_age == AGE_LOCK)
      else $error("dll locked at the wrong time");
   deselect_a: assert property (cke && cs_n && !state_r.sref && state_r.ap_pend == '0
                                |=> $stable(state_r.bank_act) && $stable(state_r.mr_cl))
      else $error("deselected command changed state");
   sref_entry_a: assert property (!state_r.sref && !cke && !cs_n && cmd == CMD_REF
                                  |=> state_r.sref && !state_r.dll_en)
      else $error("self refresh entry failed");
   // a masked rise word must leave its cell as it was
   mask_drop_a: assert property (state_r.wr_busy && dqs_i[0] && dm_i[0]
                                 |=> mem[$past(wa0)] == $past(mem[wa0]))
      else $error("masked word was written");
   wr_ap_close_a: assert property (state_r.wr_busy && state_r.wr_ap
                                   && state_r.tras_cnt[state_r.wr_bank] >= TRAS_DONE
                                   && {1'b0, state_r.wr_beat} == hb - 3'h1 && !(go && cmd == CMD_ACT)
                                   |=> ##1 !state_r.bank_act[$past(state_r.wr_bank, 2)])
      else $error("write auto precharge did not close the bank");
endmodule // ddr_cmd_core
`default_nettype wire

/* File: logic/dram_pkg.sv */
// Overview of operation
// - after dll reset, 200 cycles pass before lock
// - activate opens selected bank and latches the row address
// - precharge closes one bank, or all banks when a10 high
// - write takes column a0..a9, data on both strobe edges; the code keeps only a0..a5
// - write with auto precharge closes bank after the burst
// - read data starts cas latency clocks after the command
// - read auto precharge after half burst, held until minimum active time
// - precharge to a reading bank ends its read burst
// - extended mode set controls dll enable and drive strength; the code handles only dll enable
// - all command lines high means no operation
// - burst stop ends an ongoing read burst
// - chip select high ignores command and address, work continues
// - auto refresh ignores address and bank inputs
// - refresh encoding with clock enable low enters self refresh, dll off
// - data mask covers each word, all eight data lines together
// - a word is discarded when its mask is high
// - mode bits 2..0: 1,2,3 give burst 2,4,8
// - mode bit 3: sequential or interleaved burst order
// - mode bits 6..4: 2 or 3 give cas latency
`default_nettype none
package dram_pkg;
   localparam int NBANK    = 4;
   localparam int ROW_W    = 13;
   localparam int MEM_COLW = 6;
   localparam int MEM_AW   = 10;
   // command codes on {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // address bit roles
   localparam int AP_BIT      = 10;
   localparam int DLL_RST_BIT = 8;
   localparam int BL_LSB      = 0;
   localparam int BT_BIT      = 3;
   localparam int CL_LSB      = 4;
   localparam int DLL_DIS_BIT = 0;
   localparam logic [1:0] SEL_MRS  = 2'h0;
   localparam logic [1:0] SEL_EMRS = 2'h1;
   // mode field codes
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] CL_2 = 3'h2;
   localparam logic [2:0] CL_3 = 3'h3;
   // timing
   localparam int CLK_NS       = 20;
   localparam int TRAS_MIN_NS  = 40;
   localparam int TRAS_CYC     = (TRAS_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int DLL_LOCK_CYC = 200;
   localparam logic [3:0] TRAS_DONE = 4'(TRAS_CYC);
   localparam logic [7:0] DLL_LAST  = 8'(DLL_LOCK_CYC - 1);
endpackage
`default_nettype wire

/* File: logic/level_sync.sv */
`default_nettype none
// two-stage synchroniser for independent level bits
module level_sync #(
   parameter int W = 1
) (
   // clock and reset of the receiving side
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels in and out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_t;

   sync_t sync_r;
   sync_t sync_nxt;

   always_comb begin
      sync_nxt.meta = d;
      sync_nxt.q    = sync_r.meta;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_r <= '0;
      end else begin
         sync_r <= sync_nxt;
      end
   end

   assign q = sync_r.q;
endmodule // level_sync
`default_nettype wire
